// *** gpio_port_pkg.sv ***
// Purpose: Shared constants for the eight-pin I/O port with pin interrupts
// Assumes: Byte-wide register port, one register per address
// Notes:   Offsets, field positions, drive modes and reset values
package gpio_port_pkg;

    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 8;

    typedef logic [ADDR_W-1:0] addr_t;
    typedef logic [DATA_W-1:0] data_t;

    // Port-wide views, one bit per pin; OFS_PORT_CFG and OFS_REGULATED hold a single bit
    localparam addr_t OFS_DATA_OUT  = 8'h00;
    localparam addr_t OFS_PIN_STATE = 8'h01;
    localparam addr_t OFS_DM0       = 8'h02;
    localparam addr_t OFS_DM1       = 8'h03;
    localparam addr_t OFS_DM2       = 8'h04;
    localparam addr_t OFS_SLEW      = 8'h05;
    localparam addr_t OFS_IBUF_DIS  = 8'h06;
    localparam addr_t OFS_BIDIR_EN  = 8'h07;
    localparam addr_t OFS_IRQ_MODE0 = 8'h08;
    localparam addr_t OFS_IRQ_MODE1 = 8'h09;
    localparam addr_t OFS_IRQ_STAT  = 8'h0a;
    localparam addr_t OFS_IRQ_EN    = 8'h0b;
    localparam addr_t OFS_IRQ_CLR   = 8'h0c;
    localparam addr_t OFS_PORT_CFG  = 8'h0d;
    localparam addr_t OFS_REGULATED = 8'h0e;
    // Per-pin views at base + pin index
    localparam addr_t OFS_OE_SEL    = 8'h10;
    localparam addr_t OFS_PIN_VIEW  = 8'h20;

    // Pin-view field positions
    localparam int unsigned PV_DOUT = 0;
    localparam int unsigned PV_PIN  = 1;
    localparam int unsigned PV_DM   = 2;
    localparam int unsigned PV_BIDI = 5;
    localparam int unsigned PV_SLW  = 6;
    localparam int unsigned PV_IBD  = 7;

    // Port configuration field positions
    localparam int unsigned CFG_LVTTL = 0;

    // Drive modes held in dm2_q, dm1_q, dm0_q per pin
    localparam logic [2:0] DM_HIZ_ANALOG = 3'h0;
    localparam logic [2:0] DM_HIZ_DIGITAL = 3'h1;
    localparam logic [2:0] DM_RES_UP     = 3'h2;
    localparam logic [2:0] DM_RES_DOWN   = 3'h3;
    localparam logic [2:0] DM_OD_LOW     = 3'h4;
    localparam logic [2:0] DM_OD_HIGH    = 3'h5;
    localparam logic [2:0] DM_STRONG     = 3'h6;
    localparam logic [2:0] DM_RES_BOTH   = 3'h7;

    // Interrupt modes
    localparam logic [1:0] IM_NONE    = 2'h0;
    localparam logic [1:0] IM_RISING  = 2'h1;
    localparam logic [1:0] IM_FALLING = 2'h2;
    localparam logic [1:0] IM_BOTH    = 2'h3;

    localparam data_t RST_ZERO = 8'h00;
    localparam logic [2:0] RST_DM = DM_HIZ_ANALOG;

endpackage

// *** gpio_pin_drive.sv ***
// Purpose: Per-pin pad control from drive mode, data and output enable
// Assumes: Pad cell takes separate strong and resistive controls
// Notes:   Outputs are combinational; top registers them
`timescale 1ns/100ps
`default_nettype none
module gpio_pin_drive
    import gpio_port_pkg::*;
(
    input  wire logic [2:0] dm_i,
    input  wire logic       dout_i,
    input  wire logic       bidir_i,
    input  wire logic       aux_oe_i,
    input  wire logic       slow_i,
    input  wire logic       regulated_i,
    output logic            out_o,
    output logic            oe_n_o,
    output logic            pull_up_o,
    output logic            pull_dn_o,
    output logic            slow_o
);
    logic       active;
    logic [2:0] dm;

    always_comb begin
        active = !bidir_i || aux_oe_i;
        dm     = active ? dm_i : DM_HIZ_DIGITAL;
        out_o     = dout_i;
        oe_n_o    = 1'b1;
        pull_up_o = 1'b0;
        pull_dn_o = 1'b0;
        slow_o    = 1'b0;
        case (dm)
            DM_STRONG: begin
                oe_n_o = 1'b0;
                slow_o = slow_i;
            end
            DM_OD_LOW: begin
                oe_n_o = dout_i;
                slow_o = slow_i;
            end
            DM_OD_HIGH: begin
                oe_n_o = !dout_i;
                slow_o = slow_i;
            end
            DM_RES_UP: begin
                oe_n_o    = dout_i;
                pull_up_o = dout_i && !regulated_i;
            end
            DM_RES_DOWN: begin
                oe_n_o    = !dout_i;
                pull_dn_o = !dout_i && !regulated_i;
            end
            DM_RES_BOTH: begin
                pull_up_o = dout_i && !regulated_i;
                pull_dn_o = !dout_i && !regulated_i;
            end
            default: begin
                oe_n_o = 1'b1;
            end
        endcase
    end
endmodule
`default_nettype wire

// *** gpio_port.sv ***
// Purpose: Eight-pin I/O port with drive modes and edge interrupts
// Assumes: Pin inputs synchronous to SYS_CLK_I; single-cycle register strobes
// Notes:   All outputs registered; status clears on read or clear write
//
// The register addresses and strobed register access were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module gpio_port
    import gpio_port_pkg::*;
#(
    parameter int unsigned PINS   = 8,
    parameter int unsigned AUX_OE = 16
) (
    input  wire logic                      SYS_CLK_I,
    input  wire logic                      SYS_RST_I,
    input  wire gpio_port_pkg::addr_t      ADDR_I,
    input  wire gpio_port_pkg::data_t      WDATA_I,
    input  wire logic                      WR_I,
    input  wire logic                      RD_I,
    output gpio_port_pkg::data_t           RDATA_O,
    input  wire logic [PINS-1:0]           PIN_I,
    input  wire logic [AUX_OE-1:0]         AUX_OE_I,
    output logic [PINS-1:0]                PIN_O,
    output logic [PINS-1:0]                PIN_OE_N_O,
    output logic [PINS-1:0]                PULL_UP_O,
    output logic [PINS-1:0]                PULL_DN_O,
    output logic [PINS-1:0]                SLOW_O,
    output logic [PINS-1:0]                IBUF_DIS_O,
    output logic                           LVTTL_O,
    output logic                           IRQ_O
);
    import gpio_port_pkg::*;

    localparam int unsigned SEL_W = $clog2(AUX_OE);

    initial begin
        if (PINS != DATA_W) $error("PINS must equal the register width");
        if (AUX_OE < 2 || AUX_OE > 16) $error("AUX_OE must be 2..16");
    end

    function automatic logic hit(input addr_t a, input addr_t base);
        hit = (a == base);
    endfunction

    function automatic logic in_page(input addr_t a, input addr_t base);
        in_page = (a >= base) && (a < base + addr_t'(PINS));
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Configuration state shared by port and pin views

    logic [PINS-1:0]  dout_q;
    logic [PINS-1:0]  dm0_q, dm1_q, dm2_q;
    logic [PINS-1:0]  slew_q;
    logic [PINS-1:0]  ibd_q;
    logic [PINS-1:0]  bidi_q;
    logic [PINS-1:0]  im0_q, im1_q;
    logic [PINS-1:0]  ien_q;
    logic [PINS-1:0]  stat_q;
    logic             lvttl_q;
    logic             regulated_q;
    logic [SEL_W-1:0] oe_sel_q [PINS];
    logic [PINS-1:0]  pin_q;
    logic [2:0]       pidx;
    logic             pv_wr;

    assign pidx  = ADDR_I[2:0];
    assign pv_wr = WR_I && in_page(ADDR_I, OFS_PIN_VIEW);

    always_ff @(posedge SYS_CLK_I) begin
        if (SYS_RST_I) begin
            dout_q <= RST_ZERO;
            dm0_q  <= {PINS{RST_DM[0]}};
            dm1_q  <= {PINS{RST_DM[1]}};
            dm2_q  <= {PINS{RST_DM[2]}};
            slew_q <= RST_ZERO;
            ibd_q  <= RST_ZERO;
            bidi_q <= RST_ZERO;
        end else if (pv_wr) begin
            dout_q[pidx] <= WDATA_I[PV_DOUT];
            dm0_q[pidx]  <= WDATA_I[PV_DM];
            dm1_q[pidx]  <= WDATA_I[PV_DM+1];
            dm2_q[pidx]  <= WDATA_I[PV_DM+2];
            bidi_q[pidx] <= WDATA_I[PV_BIDI];
            slew_q[pidx] <= WDATA_I[PV_SLW];
            ibd_q[pidx]  <= WDATA_I[PV_IBD];
        end else if (WR_I) begin
            if (hit(ADDR_I, OFS_DATA_OUT)) dout_q <= WDATA_I;
            if (hit(ADDR_I, OFS_DM0)) dm0_q <= WDATA_I;
            if (hit(ADDR_I, OFS_DM1)) dm1_q <= WDATA_I;
            if (hit(ADDR_I, OFS_DM2)) dm2_q <= WDATA_I;
            if (hit(ADDR_I, OFS_SLEW)) slew_q <= WDATA_I;
            if (hit(ADDR_I, OFS_IBUF_DIS)) ibd_q <= WDATA_I;
            if (hit(ADDR_I, OFS_BIDIR_EN)) bidi_q <= WDATA_I;
        end
    end

    // Interrupt and port-level settings
    always_ff @(posedge SYS_CLK_I) begin
        if (SYS_RST_I) begin
            im0_q     <= RST_ZERO;
            im1_q     <= RST_ZERO;
            ien_q     <= RST_ZERO;
            lvttl_q   <= 1'b0;
            regulated_q <= 1'b0;
        end else if (WR_I) begin
            if (hit(ADDR_I, OFS_IRQ_MODE0)) im0_q <= WDATA_I;
            if (hit(ADDR_I, OFS_IRQ_MODE1)) im1_q <= WDATA_I;
            if (hit(ADDR_I, OFS_IRQ_EN)) ien_q <= WDATA_I;
            if (hit(ADDR_I, OFS_PORT_CFG)) lvttl_q <= WDATA_I[CFG_LVTTL];
            if (hit(ADDR_I, OFS_REGULATED)) regulated_q <= WDATA_I[0];
        end
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (SYS_RST_I) begin
            for (int i = 0; i < PINS; i++) begin
                oe_sel_q[i] <= '0;
            end
        end else if (WR_I && in_page(ADDR_I, OFS_OE_SEL)) begin
            oe_sel_q[pidx] <= WDATA_I[SEL_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Edge detection and status

    logic [PINS-1:0] pin_in;
    logic [PINS-1:0] rise, fall, evt;
    logic            stat_rd, stat_clr;

    assign pin_in   = PIN_I & ~ibd_q;
    assign rise     = pin_in & ~pin_q;
    assign fall     = ~pin_in & pin_q;
    assign stat_rd  = RD_I && hit(ADDR_I, OFS_IRQ_STAT);
    assign stat_clr = WR_I && hit(ADDR_I, OFS_IRQ_CLR);

    always_ff @(posedge SYS_CLK_I) begin
        if (SYS_RST_I) begin
            pin_q <= RST_ZERO;
        end else begin
            pin_q <= pin_in;
        end
    end

    always_comb begin
        for (int i = 0; i < PINS; i++) begin
            case ({im1_q[i], im0_q[i]})
                IM_RISING:  evt[i] = rise[i];
                IM_FALLING: evt[i] = fall[i];
                IM_BOTH:    evt[i] = rise[i] | fall[i];
                default:    evt[i] = 1'b0;
            endcase
        end
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (SYS_RST_I) begin
            stat_q <= RST_ZERO;
        end else if (stat_rd) begin
            stat_q <= evt;
        end else if (stat_clr) begin
            stat_q <= (stat_q & ~WDATA_I) | evt;
        end else begin
            stat_q <= stat_q | evt;
        end
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (SYS_RST_I) begin
            IRQ_O <= 1'b0;
        end else begin
            IRQ_O <= |(((stat_rd ? RST_ZERO : stat_q) | evt) & ien_q);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data

    always_ff @(posedge SYS_CLK_I) begin
        if (SYS_RST_I) begin
            RDATA_O <= RST_ZERO;
        end else if (!RD_I) begin
            RDATA_O <= RST_ZERO;
        end else if (in_page(ADDR_I, OFS_PIN_VIEW)) begin
            RDATA_O <= {ibd_q[pidx], slew_q[pidx], bidi_q[pidx], dm2_q[pidx],
                        dm1_q[pidx], dm0_q[pidx], pin_in[pidx], dout_q[pidx]};
        end else if (in_page(ADDR_I, OFS_OE_SEL)) begin
            RDATA_O <= DATA_W'(oe_sel_q[pidx]);
        end else begin
            case (ADDR_I)
                OFS_DATA_OUT:  RDATA_O <= dout_q;
                OFS_PIN_STATE: RDATA_O <= pin_in;
                OFS_DM0:       RDATA_O <= dm0_q;
                OFS_DM1:       RDATA_O <= dm1_q;
                OFS_DM2:       RDATA_O <= dm2_q;
                OFS_SLEW:      RDATA_O <= slew_q;
                OFS_IBUF_DIS:  RDATA_O <= ibd_q;
                OFS_BIDIR_EN:  RDATA_O <= bidi_q;
                OFS_IRQ_MODE0: RDATA_O <= im0_q;
                OFS_IRQ_MODE1: RDATA_O <= im1_q;
                OFS_IRQ_STAT:  RDATA_O <= stat_q;
                OFS_IRQ_EN:    RDATA_O <= ien_q;
                OFS_PORT_CFG:  RDATA_O <= DATA_W'(lvttl_q);
                OFS_REGULATED: RDATA_O <= DATA_W'(regulated_q);
                default:       RDATA_O <= RST_ZERO;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pad drive, one instance per pin

    logic [PINS-1:0] p_out, p_oen, p_pu, p_pd, p_slow;

    for (genvar g = 0; g < PINS; g++) begin : g_pin
        gpio_pin_drive u_drv (
            .dm_i      ({dm2_q[g], dm1_q[g], dm0_q[g]}),
            .dout_i    (dout_q[g]),
            .bidir_i   (bidi_q[g]),
            .aux_oe_i  (AUX_OE_I[oe_sel_q[g]]),
            .slow_i    (slew_q[g]),
            .regulated_i (regulated_q),
            .out_o     (p_out[g]),
            .oe_n_o    (p_oen[g]),
            .pull_up_o (p_pu[g]),
            .pull_dn_o (p_pd[g]),
            .slow_o    (p_slow[g])
        );
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (SYS_RST_I) begin
            PIN_O      <= RST_ZERO;
            PIN_OE_N_O <= {PINS{1'b1}};
            PULL_UP_O  <= RST_ZERO;
            PULL_DN_O  <= RST_ZERO;
            SLOW_O     <= RST_ZERO;
            IBUF_DIS_O <= RST_ZERO;
            LVTTL_O    <= 1'b0;
        end else begin
            PIN_O      <= p_out;
            PIN_OE_N_O <= p_oen;
            PULL_UP_O  <= p_pu;
            PULL_DN_O  <= p_pd;
            SLOW_O     <= p_slow;
            IBUF_DIS_O <= ibd_q;
            LVTTL_O    <= lvttl_q;
        end
    end

endmodule
`default_nettype wire

// *** gpio_port_asserts.sv ***
// Purpose: Port-level checks for the eight-pin I/O port
// Assumes: One clock, synchronous active-high reset
// Notes:   Bound to gpio_port at the foot of this file
`timescale 1ns/100ps
`default_nettype none
module gpio_port_asserts
    import gpio_port_pkg::*;
#(
    parameter int unsigned PINS   = 8,
    parameter int unsigned AUX_OE = 16
) (
    input  wire logic                 SYS_CLK_I,
    input  wire logic                 SYS_RST_I,
    input  wire logic                 WR_I,
    input  wire logic                 RD_I,
    input  wire gpio_port_pkg::data_t RDATA_O,
    input  wire logic [PINS-1:0]      PIN_I,
    input  wire logic [PINS-1:0]      PIN_OE_N_O,
    input  wire logic [PINS-1:0]      PULL_UP_O,
    input  wire logic [PINS-1:0]      PULL_DN_O,
    input  wire logic [PINS-1:0]      SLOW_O,
    input  wire logic [PINS-1:0]      IBUF_DIS_O,
    input  wire logic                 LVTTL_O,
    input  wire logic                 IRQ_O
);
    default clocking @(posedge SYS_CLK_I); endclocking
    default disable iff (SYS_RST_I);
////////////////////////////////////////////////////////////////////////////////
    a_reset_vals: assert property (
        $fell(SYS_RST_I) |-> PIN_OE_N_O == '1 && !IRQ_O && RDATA_O == '0)
        else $error("outputs not at reset values");
    a_rdata_idle: assert property (
        !$past(RD_I) |-> RDATA_O == '0)
        else $error("read data outside read cycle");
    a_irq_fall: assert property (
        $fell(IRQ_O) |-> $past(RD_I) || $past(RD_I, 2) || $past(WR_I) || $past(WR_I, 2) || $past(SYS_RST_I))
        else $error("interrupt dropped without bus access");
    a_irq_rise_cause: assert property (
        $rose(IRQ_O) |-> $past(WR_I) || $past(WR_I, 2) || $past(WR_I, 3)
            || $past(PIN_I) != $past(PIN_I, 2) || $past(PIN_I, 2) != $past(PIN_I, 3))
        else $error("interrupt raised without edge or write");
    a_pull_vs_drive: assert property (
        (~PIN_OE_N_O & (PULL_UP_O | PULL_DN_O)) == '0)
        else $error("pull active while driving");
    a_pull_excl: assert property (
        (PULL_UP_O & PULL_DN_O) == '0)
        else $error("pull up and down together");
    a_slew_resist: assert property (
        (SLOW_O & (PULL_UP_O | PULL_DN_O)) == '0)
        else $error("slew active in resistive state");
    a_cfg_by_write: assert property (
        $changed({LVTTL_O, IBUF_DIS_O}) |-> $past(WR_I) || $past(WR_I, 2) || $past(WR_I, 3) || $past(SYS_RST_I))
        else $error("input config changed without write");
////////////////////////////////////////////////////////////////////////////////
    c_irq: cover property ($rose(IRQ_O));
    c_drive: cover property (PIN_OE_N_O != '1);
    c_pull: cover property (PULL_UP_O != '0);
endmodule
bind gpio_port gpio_port_asserts #(.PINS(PINS), .AUX_OE(AUX_OE)) u_chk (
    .SYS_CLK_I(SYS_CLK_I), .SYS_RST_I(SYS_RST_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O),
    .PIN_I(PIN_I), .PIN_OE_N_O(PIN_OE_N_O), .PULL_UP_O(PULL_UP_O), .PULL_DN_O(PULL_DN_O),
    .SLOW_O(SLOW_O), .IBUF_DIS_O(IBUF_DIS_O), .LVTTL_O(LVTTL_O), .IRQ_O(IRQ_O));
`default_nettype wire

// *** gpio_pad_model.sv ***
// Purpose: Circuitry outside the port pins
// Assumes: Port drive wins over external drive
// Notes:   Undriven pins without pull toggle every cycle
`timescale 1ns/100ps
`default_nettype none
module gpio_pad_model (
    input  wire logic       clk_i,
    input  wire logic [7:0] drv_i,
    input  wire logic [7:0] oe_n_i,
    input  wire logic [7:0] pu_i,
    input  wire logic [7:0] pd_i,
    input  wire logic [7:0] ext_en_i,
    input  wire logic [7:0] ext_i,
    output logic      [7:0] level_o
);
    logic flt_q = 1'b0;
    always @(posedge clk_i) begin
        flt_q <= !flt_q;
    end
    assign level_o = (~oe_n_i & drv_i) | (oe_n_i & ext_en_i & ext_i)
                   | (oe_n_i & ~ext_en_i & (pu_i | (~pd_i & {8{flt_q}})));
endmodule
`default_nettype wire

// *** gpio_port_tb_top.sv ***
// Purpose: Self-checking bench for the I/O port
// Assumes: Pads resolved by gpio_pad_model
// Notes:   Reads queue their expected data for the monitor
`timescale 1ns/100ps
`default_nettype none
module gpio_port_tb_top;
    import gpio_port_pkg::*;
    localparam addr_t RL [9] = '{OFS_DATA_OUT, OFS_DM0, OFS_DM1, OFS_DM2, OFS_SLEW, OFS_BIDIR_EN,
                                 OFS_IRQ_MODE0, OFS_IRQ_MODE1, OFS_IRQ_EN};
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    addr_t       addr = '0;
    data_t       wdata = '0;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [15:0] aux = '0;
    logic [7:0]  ext = '0;
    data_t       rdata;
    logic [7:0]  pin_in, pin_o, oe_n, pu, pd, slow, ibd;
    logic        lvttl, irq, rd_q;
    int          n_errors = 0;
    int          num_checks = 0;
    int          seed = 32'h80b5;
    data_t       exp_q [$];
    data_t       rv [16];
    data_t       w;
////////////////////////////////////////////////////////////////////////////////
    gpio_port u_dut (.SYS_CLK_I(clk), .SYS_RST_I(rst), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd),
        .RDATA_O(rdata), .PIN_I(pin_in), .AUX_OE_I(aux), .PIN_O(pin_o), .PIN_OE_N_O(oe_n), .PULL_UP_O(pu),
        .PULL_DN_O(pd), .SLOW_O(slow), .IBUF_DIS_O(ibd), .LVTTL_O(lvttl), .IRQ_O(irq));
    gpio_pad_model u_pad (.clk_i(clk), .drv_i(pin_o), .oe_n_i(oe_n), .pu_i(pu), .pd_i(pd), .ext_en_i(8'hff),
        .ext_i(ext), .level_o(pin_in));
    always #25 clk = ~clk;
////////////////////////////////////////////////////////////////////////////////
    task automatic cmp(input data_t g, input data_t e);
        num_checks++;
        if (g !== e) begin
            n_errors++;
            $display("BAD %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic bus(input logic w_s, input logic r_s, input addr_t a, input data_t d);
        wr <= w_s;
        rd <= r_s;
        addr <= a;
        wdata <= d;
        @(posedge clk);
    endtask
    task automatic wrt(input addr_t a, input data_t d);
        bus(1'b1, 1'b0, a, d);
    endtask
    task automatic rdc(input addr_t a, input data_t e);
        exp_q.push_back(e);
        bus(1'b0, 1'b1, a, '0);
    endtask
    task automatic idle(input int n);
        repeat (n) bus(1'b0, 1'b0, '0, '0);
    endtask
    task automatic rst_dut;
        rst <= 1'b1;
        idle(3);
        rst <= 1'b0;
    endtask
    function automatic data_t pv(input int k);
        return {1'b1, rv[5][k], rv[7][k], rv[4][k], rv[3][k], rv[2][k], 1'b0, rv[0][k]};
    endfunction
    task automatic padc(input logic [2:0] dm, input logic d, input logic g);
        logic  drv;
        logic  res;
        data_t e;
        data_t m;
        drv = dm == DM_STRONG || (dm == DM_OD_LOW || dm == DM_RES_UP) && !d
              || (dm == DM_OD_HIGH || dm == DM_RES_DOWN) && d;
        res = dm == DM_RES_BOTH || dm == DM_RES_UP || dm == DM_RES_DOWN;
        e = {3'h0, !drv, res && !g && d && dm != DM_RES_DOWN, res && !g && !d && dm != DM_RES_UP, drv && !res, d};
        m = {6'h3f, drv || dm < DM_OD_LOW || res, drv};
        cmp({3'h0, oe_n[0], pu[0], pd[0], slow[0], pin_o[0]} & m, e & m);
    endtask
    task automatic report_and_stop;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
////////////////////////////////////////////////////////////////////////////////
    always @(posedge clk) rd_q <= rd;
    always @(negedge clk) begin
        if (rd_q) cmp(rdata, exp_q.pop_front());
    end
    initial begin
        repeat (5000) @(posedge clk);
        n_errors++;
        report_and_stop();
    end
    initial begin
        rst_dut();
        cmp(oe_n, 8'hff);
        rdc(OFS_DM0, 8'h00);
        foreach (RL[j]) begin
            w = data_t'($random(seed));
            rv[RL[j][3:0]] = w;
            wrt(RL[j], w);
            rdc(RL[j], w);
        end
        wrt(OFS_IBUF_DIS, 8'hff);
        for (int k = 0; k < 8; k++) rdc(OFS_PIN_VIEW | addr_t'(k), pv(k));
        w = (data_t'($random(seed)) | 8'h80) & 8'hfd;
        wrt(OFS_PIN_VIEW | 8'h03, w);
        rv[0][3] = w[0];
        rv[2][3] = w[2];
        rv[3][3] = w[3];
        rv[4][3] = w[4];
        rv[7][3] = w[5];
        rv[5][3] = w[6];
        foreach (RL[j]) rdc(RL[j], rv[RL[j][3:0]]);
        wrt(8'h3f, 8'hff);
        rdc(8'h3f, 8'h00);
        wrt(OFS_PORT_CFG, 8'h01);
        idle(3);
        cmp({7'h0, lvttl}, 8'h01);
        cmp(ibd, 8'hff);
        for (int g = 0; g < 2; g++) begin
            wrt(OFS_REGULATED, data_t'(g));
            for (int m = 0; m < 16; m++) begin
                wrt(OFS_PIN_VIEW, {3'b010, 3'(m >> 1), 1'b0, m[0]});
                idle(3);
                padc(3'(m >> 1), m[0], g[0]);
            end
        end
        wrt(OFS_PIN_VIEW, 8'h39);
        for (int k = 0; k < 16; k++) begin
            wrt(OFS_OE_SEL, data_t'(k));
            aux <= ~(16'h1 << k);
            idle(3);
            cmp({7'h0, oe_n[0]}, 8'h01);
            aux <= 16'h1 << k;
            idle(3);
            cmp({7'h0, oe_n[0]}, 8'h00);
        end
        rdc(OFS_OE_SEL, 8'h0f);
        rst_dut();
        wrt(OFS_IRQ_MODE0, 8'haa);
        wrt(OFS_IRQ_MODE1, 8'hcc);
        wrt(OFS_IRQ_EN, 8'hff);
        wrt(OFS_IBUF_DIS, 8'h02);
        idle(4);
        rdc(OFS_IRQ_STAT, 8'h00);
        ext <= 8'hff;
        idle(4);
        cmp({7'h0, irq}, 8'h01);
        rdc(OFS_PIN_STATE, 8'hfd);
        rdc(OFS_IRQ_STAT, 8'ha8);
        rdc(OFS_IRQ_STAT, 8'h00);
        idle(2);
        cmp({7'h0, irq}, 8'h00);
        wrt(OFS_IRQ_EN, 8'h30);
        ext <= 8'h00;
        idle(4);
        cmp({7'h0, irq}, 8'h00);
        wrt(OFS_IRQ_EN, 8'hff);
        idle(2);
        cmp({7'h0, irq}, 8'h01);
        wrt(OFS_IRQ_CLR, 8'h0c);
        rdc(OFS_IRQ_STAT, 8'hc0);
        idle(2);
        cmp({7'h0, irq}, 8'h00);
        report_and_stop();
    end
endmodule
`default_nettype wire
